/* hw/clock_dist_pkg.sv */
// Package with register map, field layout, reset values and state types of the output clock distribution.
package clock_dist_pkg;

  // ---------------------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------------------
  localparam logic [15:0] FIRST_OUTPUT_PAIR_CONFIG_OFS       = 16'h0501;
  localparam logic [15:0] CHANNEL_ZERO_DIVIDER_LOW_OFS       = 16'h0502;
  localparam logic [15:0] CHANNEL_ZERO_DIVIDER_HIGH_CTRL_OFS = 16'h0503;
  localparam logic [15:0] CHANNEL_ZERO_DIVIDER_PHASE_OFS     = 16'h0504;
  localparam logic [15:0] SECOND_OUTPUT_PAIR_CONFIG_OFS      = 16'h0505;
  localparam logic [15:0] DISTRIBUTION_SPARE_OFS             = 16'h0506;

  // ---------------------------------------------------------------------------
  // Reset values and writable-bit masks
  // ---------------------------------------------------------------------------
  localparam logic [7:0] FIRST_PAIR_RESET  = 8'h10;
  localparam logic [7:0] DIV_LOW_RESET     = 8'h00;
  localparam logic [7:0] DIV_HIGH_RESET    = 8'h00;
  localparam logic [7:0] DIV_PHASE_RESET   = 8'h00;
  localparam logic [7:0] SECOND_PAIR_RESET = 8'h10;
  localparam logic [7:0] DIV_HIGH_MASK     = 8'h0F;
  localparam logic [7:0] DIV_PHASE_MASK    = 8'h3F;
  localparam logic [7:0] SECOND_PAIR_MASK  = 8'h7F;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int CMOS33_BIT     = 7;
  localparam int FORMAT_MSB     = 6;
  localparam int FORMAT_LSB     = 4;
  localparam int POLARITY_MSB   = 3;
  localparam int POLARITY_LSB   = 2;
  localparam int STRENGTH_BIT   = 1;
  localparam int ENABLE_BIT     = 0;
  localparam int POWER_DOWN_BIT = 3;
  localparam int PRESCALER_BIT  = 2;
  localparam int DIV_HIGH_MSB   = 1;
  localparam int PHASE_MSB      = 5;

  // ---------------------------------------------------------------------------
  // Output pair format codes and polarity default
  // ---------------------------------------------------------------------------
  localparam logic [2:0] FMT_POWER_DOWN = 3'h0;
  localparam logic [2:0] FMT_HSTL       = 3'h1;
  localparam logic [2:0] FMT_LVDS       = 3'h2;
  localparam logic [2:0] FMT_CMOS_BOTH  = 3'h4;
  localparam logic [2:0] FMT_CMOS_P     = 3'h5;
  localparam logic [2:0] FMT_CMOS_N     = 3'h6;
  localparam logic [1:0] POL_DEFAULT    = 2'h0;

  // ---------------------------------------------------------------------------
  // Divider states
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    DIV_OFF  = 3'b001,
    DIV_HOLD = 3'b010,
    DIV_RUN  = 3'b100
  } div_state_t;

endpackage

/* hw/channel_divider.sv */
// Channel divider counting half periods of its input clock, with sync hold and phase preload.
`timescale 1ns/1ns
module channel_divider #(
  parameter int DIV_WIDTH   = 10,
  parameter int PHASE_WIDTH = 6
) (
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire logic                   halfTick,
  input  wire logic [DIV_WIDTH-1:0]   ratio,
  input  wire logic [PHASE_WIDTH-1:0] phase,
  input  wire logic                   powerDown,
  input  wire logic                   syncMask,
  input  wire logic                   syncPulse,
  output logic                        divClk,
  output logic                        running
);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  clock_dist_pkg::div_state_t state_q;
  clock_dist_pkg::div_state_t state_d;
  logic [DIV_WIDTH:0]         cnt_q;
  logic [DIV_WIDTH:0]         cnt_d;
  logic                       clk_d;
  logic [DIV_WIDTH:0]         limit;
  logic [DIV_WIDTH:0]         phaseLoad;

  // One output period is 2*(ratio+1) half periods; offsets past the period clamp to its end.
  always_comb begin
    limit     = {ratio, 1'b1};
    phaseLoad = (DIV_WIDTH + 1)'(phase);
    if (phaseLoad > limit) begin
      phaseLoad = limit;
    end
  end

  // Next state: power down wins, the held divider waits for sync unless masked.
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    if (powerDown) begin
      state_d = clock_dist_pkg::DIV_OFF;
      cnt_d   = '0;
    end else begin
      unique case (state_q)
        clock_dist_pkg::DIV_OFF: begin
          state_d = clock_dist_pkg::DIV_HOLD;
          cnt_d   = '0;
        end
        clock_dist_pkg::DIV_HOLD: begin
          if (syncMask) begin
            state_d = clock_dist_pkg::DIV_RUN;
            cnt_d   = '0;
          end else if (syncPulse) begin
            state_d = clock_dist_pkg::DIV_RUN;
            cnt_d   = phaseLoad;
          end
        end
        clock_dist_pkg::DIV_RUN: begin
          if (syncPulse && !syncMask) begin
            cnt_d = phaseLoad;
          end else if (halfTick) begin
            cnt_d = (cnt_q >= limit) ? '0 : cnt_q + 1'b1;
          end
        end
        default: begin
          state_d = clock_dist_pkg::DIV_OFF;
          cnt_d   = '0;
        end
      endcase
    end
    clk_d = (state_d == clock_dist_pkg::DIV_RUN) && (cnt_d <= (DIV_WIDTH + 1)'(ratio));
  end

  // Registers only.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= clock_dist_pkg::DIV_HOLD;
      cnt_q   <= '0;
      divClk  <= 1'b0;
      running <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      divClk  <= clk_d;
      running <= (state_d == clock_dist_pkg::DIV_RUN);
    end
  end

endmodule

/* hw/output_clock_distribution_cfg.sv */
// Output clock distribution: configuration registers, channel zero divider and two output pairs.
//
// Summary of operation
// - Divide channel zero by ten-bit value plus one.
// - Power-down bit stops channel zero divider.
// - Select bit picks second or first prescaler.
// - After sync, preload phase in half periods.
// - First pair format from three-bit field.
// - Second pair format, same encoding.
// - First pair polarity from two-bit field.
// - Second pair polarity only in CMOS modes.
// - High-voltage CMOS select drives first pair.
// - First pair enable ignored under 3.3 V.
// - First pair drive level bit.
// - Second pair LVDS drive level bit.
// - Second pair enable bit, off after reset.
// - Unmasked divider stays static until sync.
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ns
module output_clock_distribution_cfg #(
  parameter int ADDR_WIDTH  = 16,
  parameter int DIV_WIDTH   = 10,
  parameter int PHASE_WIDTH = 6
) (
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic [ADDR_WIDTH-1:0] regAddr,
  input  wire logic [7:0]            regWrData,
  input  wire logic                  regWrStrobe,
  input  wire logic                  regRdStrobe,
  output logic [7:0]                 regRdData,
  input  wire logic                  firstPrescalerTick,
  input  wire logic                  secondPrescalerTick,
  input  wire logic                  syncPulse,
  input  wire logic                  syncMask,
  output logic                       dividerRunning,
  output logic                       firstPairP,
  output logic                       firstPairN,
  output logic                       firstPairDriverOn,
  output logic                       firstPairCmos33,
  output logic                       firstPairBoost,
  output logic [2:0]                 firstPairMode,
  output logic                       secondPairP,
  output logic                       secondPairN,
  output logic                       secondPairDriverOn,
  output logic                       secondPairBoost,
  output logic [2:0]                 secondPairMode
);

  // ---------------------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------------------

  // A format code is legal unless it is the power-down code or one of the two reserved codes.
  function automatic logic fmtValid(input logic [2:0] fmt);
    fmtValid = (fmt == clock_dist_pkg::FMT_HSTL) || (fmt == clock_dist_pkg::FMT_LVDS) ||
               (fmt == clock_dist_pkg::FMT_CMOS_BOTH) || (fmt == clock_dist_pkg::FMT_CMOS_P) ||
               (fmt == clock_dist_pkg::FMT_CMOS_N);
  endfunction

  // True for the three CMOS codes.
  function automatic logic fmtCmos(input logic [2:0] fmt);
    fmtCmos = (fmt == clock_dist_pkg::FMT_CMOS_BOTH) || (fmt == clock_dist_pkg::FMT_CMOS_P) ||
              (fmt == clock_dist_pkg::FMT_CMOS_N);
  endfunction

  // Polarity: bit one inverts P; N is inverted when both bits agree.
  function automatic logic [1:0] pairLevels(input logic divClkIn, input logic [1:0] pol,
                                            input logic [2:0] fmt, input logic on);
    logic p;
    logic n;
    p = divClkIn ^ pol[1];
    n = divClkIn ^ ~(pol[1] ^ pol[0]);
    if (!on || (fmt == clock_dist_pkg::FMT_CMOS_N)) begin
      p = 1'b0;
    end
    if (!on || (fmt == clock_dist_pkg::FMT_CMOS_P)) begin
      n = 1'b0;
    end
    pairLevels = {p, n};
  endfunction

  // ---------------------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------------------
  logic [7:0] firstPairCfg_q;
  logic [7:0] firstPairCfg_d;
  logic [7:0] divLow_q;
  logic [7:0] divLow_d;
  logic [7:0] divHigh_q;
  logic [7:0] divHigh_d;
  logic [7:0] divPhase_q;
  logic [7:0] divPhase_d;
  logic [7:0] secondPairCfg_q;
  logic [7:0] secondPairCfg_d;
  logic [7:0] rdData_d;

  // Writes land only in defined bits; the spare register and unmapped addresses swallow them.
  always_comb begin
    firstPairCfg_d  = firstPairCfg_q;
    divLow_d        = divLow_q;
    divHigh_d       = divHigh_q;
    divPhase_d      = divPhase_q;
    secondPairCfg_d = secondPairCfg_q;
    if (regWrStrobe) begin
      unique case (regAddr)
        clock_dist_pkg::FIRST_OUTPUT_PAIR_CONFIG_OFS:
          firstPairCfg_d = regWrData;
        clock_dist_pkg::CHANNEL_ZERO_DIVIDER_LOW_OFS:
          divLow_d = regWrData;
        clock_dist_pkg::CHANNEL_ZERO_DIVIDER_HIGH_CTRL_OFS:
          divHigh_d = regWrData & clock_dist_pkg::DIV_HIGH_MASK;
        clock_dist_pkg::CHANNEL_ZERO_DIVIDER_PHASE_OFS:
          divPhase_d = regWrData & clock_dist_pkg::DIV_PHASE_MASK;
        clock_dist_pkg::SECOND_OUTPUT_PAIR_CONFIG_OFS:
          secondPairCfg_d = regWrData & clock_dist_pkg::SECOND_PAIR_MASK;
        default: ;
      endcase
    end
  end

  // Read mux; the spare register and unknown addresses read zero.
  always_comb begin
    rdData_d = '0;
    if (regRdStrobe) begin
      unique case (regAddr)
        clock_dist_pkg::FIRST_OUTPUT_PAIR_CONFIG_OFS:       rdData_d = firstPairCfg_q;
        clock_dist_pkg::CHANNEL_ZERO_DIVIDER_LOW_OFS:       rdData_d = divLow_q;
        clock_dist_pkg::CHANNEL_ZERO_DIVIDER_HIGH_CTRL_OFS: rdData_d = divHigh_q;
        clock_dist_pkg::CHANNEL_ZERO_DIVIDER_PHASE_OFS:     rdData_d = divPhase_q;
        clock_dist_pkg::SECOND_OUTPUT_PAIR_CONFIG_OFS:      rdData_d = secondPairCfg_q;
        default:                                            rdData_d = '0;
      endcase
    end
  end

  // Register bank and read data; read data stand only in the cycle after the strobe.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      firstPairCfg_q  <= clock_dist_pkg::FIRST_PAIR_RESET;
      divLow_q        <= clock_dist_pkg::DIV_LOW_RESET;
      divHigh_q       <= clock_dist_pkg::DIV_HIGH_RESET;
      divPhase_q      <= clock_dist_pkg::DIV_PHASE_RESET;
      secondPairCfg_q <= clock_dist_pkg::SECOND_PAIR_RESET;
      regRdData       <= '0;
    end else begin
      firstPairCfg_q  <= firstPairCfg_d;
      divLow_q        <= divLow_d;
      divHigh_q       <= divHigh_d;
      divPhase_q      <= divPhase_d;
      secondPairCfg_q <= secondPairCfg_d;
      regRdData       <= rdData_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Channel zero divider
  // ---------------------------------------------------------------------------
  logic                   halfTick;
  logic [DIV_WIDTH-1:0]   divRatio;
  logic [PHASE_WIDTH-1:0] divPhaseVal;
  logic                   divClk;
  logic                   divRun;

  // Each prescaler tick marks one half period of the divider input clock.
  always_comb begin
    halfTick    = divHigh_q[clock_dist_pkg::PRESCALER_BIT] ? secondPrescalerTick : firstPrescalerTick;
    divRatio    = {divHigh_q[clock_dist_pkg::DIV_HIGH_MSB:0], divLow_q};
    divPhaseVal = divPhase_q[clock_dist_pkg::PHASE_MSB:0];
  end

  channel_divider #(
    .DIV_WIDTH   (DIV_WIDTH),
    .PHASE_WIDTH (PHASE_WIDTH)
  ) u_div0 (
    .clk       (clk),
    .rst_n     (rst_n),
    .halfTick  (halfTick),
    .ratio     (divRatio),
    .phase     (divPhaseVal),
    .powerDown (divHigh_q[clock_dist_pkg::POWER_DOWN_BIT]),
    .syncMask  (syncMask),
    .syncPulse (syncPulse),
    .divClk    (divClk),
    .running   (divRun)
  );

  // ---------------------------------------------------------------------------
  // Output pairs
  // ---------------------------------------------------------------------------
  logic [2:0] fmt0;
  logic [2:0] fmt1;
  logic [1:0] pol1;
  logic       cmos33;
  logic       on0;
  logic       on1;
  logic [1:0] lv0;
  logic [1:0] lv1;

  // Driver controls; reserved codes behave like power-down so nothing toggles.
  always_comb begin
    fmt0   = firstPairCfg_q[clock_dist_pkg::FORMAT_MSB:clock_dist_pkg::FORMAT_LSB];
    fmt1   = secondPairCfg_q[clock_dist_pkg::FORMAT_MSB:clock_dist_pkg::FORMAT_LSB];
    cmos33 = firstPairCfg_q[clock_dist_pkg::CMOS33_BIT] && fmtCmos(fmt0);
    on0    = fmtValid(fmt0) && (cmos33 || firstPairCfg_q[clock_dist_pkg::ENABLE_BIT]);
    on1    = fmtValid(fmt1) && secondPairCfg_q[clock_dist_pkg::ENABLE_BIT];
    pol1   = fmtCmos(fmt1) ?
             secondPairCfg_q[clock_dist_pkg::POLARITY_MSB:clock_dist_pkg::POLARITY_LSB] :
             clock_dist_pkg::POL_DEFAULT;
    lv0    = pairLevels(divClk,
                        firstPairCfg_q[clock_dist_pkg::POLARITY_MSB:clock_dist_pkg::POLARITY_LSB],
                        fmt0, on0 && divRun);
    lv1    = pairLevels(divClk, pol1, fmt1, on1 && divRun);
  end

  // All outputs come from flops; the pin levels lag the divider by one cycle.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dividerRunning     <= 1'b0;
      firstPairP         <= 1'b0;
      firstPairN         <= 1'b0;
      firstPairDriverOn  <= 1'b0;
      firstPairCmos33    <= 1'b0;
      firstPairBoost     <= 1'b0;
      firstPairMode      <= clock_dist_pkg::FMT_HSTL;
      secondPairP        <= 1'b0;
      secondPairN        <= 1'b0;
      secondPairDriverOn <= 1'b0;
      secondPairBoost    <= 1'b0;
      secondPairMode     <= clock_dist_pkg::FMT_HSTL;
    end else begin
      dividerRunning     <= divRun;
      firstPairP         <= lv0[1];
      firstPairN         <= lv0[0];
      firstPairDriverOn  <= on0;
      firstPairCmos33    <= cmos33;
      firstPairBoost     <= firstPairCfg_q[clock_dist_pkg::STRENGTH_BIT];
      firstPairMode      <= fmtValid(fmt0) ? fmt0 : clock_dist_pkg::FMT_POWER_DOWN;
      secondPairP        <= lv1[1];
      secondPairN        <= lv1[0];
      secondPairDriverOn <= on1;
      secondPairBoost    <= secondPairCfg_q[clock_dist_pkg::STRENGTH_BIT];
      secondPairMode     <= fmtValid(fmt1) ? fmt1 : clock_dist_pkg::FMT_POWER_DOWN;
    end
  end

endmodule

/* test/output_clock_distribution_properties.sv */
// Port-level assertions for the output clock distribution block.
`timescale 1ns/1ns
module output_clock_distribution_properties #(
  parameter int ADDR_WIDTH = 16
) (
  input wire logic                  clk,
  input wire logic                  rst_n,
  input wire logic [ADDR_WIDTH-1:0] regAddr,
  input wire logic [7:0]            regWrData,
  input wire logic                  regWrStrobe,
  input wire logic                  regRdStrobe,
  input wire logic [7:0]            regRdData,
  input wire logic                  syncPulse,
  input wire logic                  syncMask,
  input wire logic                  dividerRunning,
  input wire logic                  firstPairP,
  input wire logic                  firstPairN,
  input wire logic                  firstPairDriverOn,
  input wire logic                  firstPairCmos33,
  input wire logic [2:0]            firstPairMode,
  input wire logic                  secondPairP,
  input wire logic                  secondPairN,
  input wire logic                  secondPairDriverOn,
  input wire logic [2:0]            secondPairMode
);
  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // Read data stand one cycle only, so a stale value is caught.
  rd_idle_zero_a: assert property (!$past(regRdStrobe) |-> regRdData == 8'h00)
    else $error("read data not zero outside a read");
  spare_reads_zero_a: assert property ($past(regRdStrobe) && $past(regAddr) == 16'h0506 |->
    regRdData == 8'h00)
    else $error("spare register read not zero");
  resv_bits_zero_a: assert property ($past(regRdStrobe) && $past(regAddr) == 16'h0503 |->
    regRdData[7:4] == 4'h0)
    else $error("reserved bits read not zero");
  // Reserved format codes must never reach the drivers.
  mode_code_legal_a: assert property (firstPairMode[1:0] != 2'h3 && secondPairMode[1:0] != 2'h3)
    else $error("reserved format code on a pair");
  cmos33_needs_cmos_a: assert property (firstPairCmos33 |-> firstPairMode[2])
    else $error("high-voltage driver outside a CMOS format");
  // The divider may only start from a sync or from the mask.
  run_needs_start_a: assert property ($rose(dividerRunning) |-> $past(syncPulse, 2) || $past(syncMask, 2))
    else $error("divider started without sync or mask");
  idle_pins_low_a: assert property (!dividerRunning && !$past(dividerRunning) |->
    !firstPairP && !firstPairN && !secondPairP && !secondPairN)
    else $error("pins toggle while divider stands");
  first_off_quiet_a: assert property (!firstPairDriverOn && !$past(firstPairDriverOn) |->
    !firstPairP && !firstPairN)
    else $error("first pair pins move while off");
  second_off_quiet_a: assert property (!secondPairDriverOn && !$past(secondPairDriverOn) |->
    !secondPairP && !secondPairN)
    else $error("second pair pins move while off");
  unused_n_low_a: assert property (secondPairMode == 3'h5 && $stable(secondPairMode) |-> !secondPairN)
    else $error("unused side of second pair moves");
  pd_stops_run_a: assert property (regWrStrobe && regAddr == 16'h0503 && regWrData[3] |->
    ##[1:3] !dividerRunning)
    else $error("divider still runs after power down");

  // Main scenarios that must be reached.
  cover property ($rose(dividerRunning));
  cover property ($past(regRdStrobe) && $past(regAddr) == 16'h0506);
  cover property (secondPairMode == 3'h5 && secondPairP);
  cover property (firstPairCmos33 && firstPairDriverOn);
endmodule

bind output_clock_distribution_cfg output_clock_distribution_properties #(.ADDR_WIDTH(ADDR_WIDTH)) props_i (
  .clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData), .regWrStrobe(regWrStrobe),
  .regRdStrobe(regRdStrobe), .regRdData(regRdData), .syncPulse(syncPulse), .syncMask(syncMask),
  .dividerRunning(dividerRunning), .firstPairP(firstPairP), .firstPairN(firstPairN),
  .firstPairDriverOn(firstPairDriverOn), .firstPairCmos33(firstPairCmos33), .firstPairMode(firstPairMode),
  .secondPairP(secondPairP), .secondPairN(secondPairN), .secondPairDriverOn(secondPairDriverOn),
  .secondPairMode(secondPairMode)
);

/* test/output_pair_receiver.sv */
// Downstream receiver model that times the rising edges of one clock pin.
`timescale 1ns/1ns
module output_pair_receiver (
  input  wire logic   clk,
  input  wire logic   clkIn,
  output logic [31:0] period,
  output logic [31:0] rises
);
  logic [31:0] now;
  logic [31:0] lastRise;
  logic        prevIn;

  // Start clean; an unknown pin before reset never counts as an edge.
  initial begin
    now = 32'h0000_0000;
    lastRise = 32'h0000_0000;
    period = 32'h0000_0000;
    rises = 32'h0000_0000;
    prevIn = 1'h0;
  end

  // Time stamps rising edges in system cycles, as a sampling receiver would.
  always @(posedge clk) begin
    now <= now + 32'h0000_0001;
    prevIn <= clkIn;
    if (clkIn && !prevIn) begin
      period <= now - lastRise;
      lastRise <= now;
      rises <= rises + 32'h0000_0001;
    end
  end
endmodule

/* test/output_clock_distribution_cfg_tb.sv */
// Self-checking testbench of the output clock distribution block.
`timescale 1ns/1ns
module output_clock_distribution_cfg_tb;
  // ---------------------------------------------------------------
  // Signals and tables
  // ---------------------------------------------------------------
  logic        clk, rst_n, regWrStrobe, regRdStrobe, syncPulse, syncMask;
  logic        firstPrescalerTick, secondPrescalerTick, dividerRunning;
  logic        firstPairP, firstPairN, firstPairDriverOn, firstPairCmos33, firstPairBoost;
  logic        secondPairP, secondPairN, secondPairDriverOn, secondPairBoost;
  logic [15:0] regAddr;
  logic [7:0]  regWrData, regRdData, d;
  logic [2:0]  firstPairMode, secondPairMode;
  logic [1:0]  slowCnt;
  logic [31:0] period, rises;
  int          failures, cmp_count, k, hiLen[2];
  localparam logic [7:0] RST_V [7] = '{8'h00, 8'h10, 8'h00, 8'h00, 8'h00, 8'h10, 8'h00};
  localparam logic [7:0] ONE_V [6] = '{8'hFF, 8'hFF, 8'h0F, 8'h3F, 8'h7F, 8'h00};
  localparam logic [7:0] LO    [4] = '{8'h00, 8'h03, 8'hFF, 8'h02};
  localparam logic [7:0] HI    [4] = '{8'h00, 8'h00, 8'h03, 8'h04};
  localparam logic [7:0] DRV   [4] = '{8'hC0, 8'h41, 8'h40, 8'h93};
  localparam logic [2:0] DRV_X [4] = '{3'h6, 3'h4, 3'h0, 3'h5};

  output_clock_distribution_cfg output_clock_distribution_cfg_i (
    .clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData), .regWrStrobe(regWrStrobe),
    .regRdStrobe(regRdStrobe), .regRdData(regRdData), .firstPrescalerTick(firstPrescalerTick),
    .secondPrescalerTick(secondPrescalerTick), .syncPulse(syncPulse), .syncMask(syncMask),
    .dividerRunning(dividerRunning), .firstPairP(firstPairP), .firstPairN(firstPairN),
    .firstPairDriverOn(firstPairDriverOn), .firstPairCmos33(firstPairCmos33), .firstPairBoost(firstPairBoost),
    .firstPairMode(firstPairMode), .secondPairP(secondPairP), .secondPairN(secondPairN),
    .secondPairDriverOn(secondPairDriverOn), .secondPairBoost(secondPairBoost), .secondPairMode(secondPairMode)
  );
  output_pair_receiver output_pair_receiver_i (.clk(clk), .clkIn(firstPairP), .period(period), .rises(rises));

  // ---------------------------------------------------------------
  // Clock, prescaler ticks and tasks
  // ---------------------------------------------------------------
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  // Ticks every second and every third cycle, so the chosen source shows in the period.
  always @(posedge clk) begin
    slowCnt <= (slowCnt == 2'h2) ? 2'h0 : slowCnt + 2'h1;
    firstPrescalerTick <= ~firstPrescalerTick;
    secondPrescalerTick <= (slowCnt == 2'h2);
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Each access starts on an edge, so back-to-back calls never drive a strobe twice in one step.
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge clk);
    regAddr <= a;
    regWrData <= v;
    regWrStrobe <= 1'h1;
    @(posedge clk);
    regWrStrobe <= 1'h0;
  endtask

  task automatic rd(input logic [15:0] a, output logic [7:0] v);
    @(posedge clk);
    regAddr <= a;
    regRdStrobe <= 1'h1;
    @(posedge clk);
    regRdStrobe <= 1'h0;
    #1;
    v = regRdData;
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Sync is aligned to the first tick so that runs can be compared cycle for cycle.
  task automatic sync_now();
    int n = 0;
    do begin
      cycles(1);
      n++;
    end while (firstPrescalerTick !== 1'h1 && n < 8);
    if (firstPrescalerTick !== 1'h1) begin
      failures++;
      final_report();
    end
    @(posedge clk);
    syncPulse <= 1'h1;
    @(posedge clk);
    syncPulse <= 1'h0;
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    {rst_n, regWrStrobe, regRdStrobe, syncPulse, syncMask} = 5'h00;
    {firstPrescalerTick, secondPrescalerTick, slowCnt} = 4'h0;
    {regAddr, regWrData} = 24'h00_0000;
    failures = 0;
    cmp_count = 0;
    repeat (4) @(posedge clk);
    rst_n <= 1'h1;
    for (int i = 0; i < 7; i++) begin
      rd(16'h0500 + 16'(i), d);
      check("reset value", d, RST_V[i]);
    end
    check("running before sync", dividerRunning, 1'h0);
    for (int i = 0; i < 6; i++) begin
      wr(16'h0501 + 16'(i), 8'hFF);
      rd(16'h0501 + 16'(i), d);
      check("readback", d, ONE_V[i]);
    end
    wr(16'h0501, 8'h11);
    wr(16'h0504, 8'h00);
    foreach (LO[i]) begin
      wr(16'h0502, LO[i]);
      wr(16'h0503, HI[i]);
      sync_now();
      k = rises + 4;
      for (int n = 0; n < 20000 && rises < k; n++) cycles(1);
      if (rises < k) begin
        failures++;
        final_report();
      end
      check("period", period[15:0], 16'(2 * ({HI[i][1:0], LO[i]} + 1) * (HI[i][2] ? 3 : 2)));
      check("running", dividerRunning, 1'h1);
    end
    // Phase 5 of a divide-by-8 must end the first high half five ticks early.
    wr(16'h0502, 8'h07);
    wr(16'h0503, 8'h00);
    for (int p = 0; p < 2; p++) begin
      wr(16'h0504, p ? 8'h05 : 8'h00);
      sync_now();
      cycles(3);
      k = 0;
      while (firstPairP !== 1'h0 && k < 64) begin
        cycles(1);
        k++;
      end
      if (k >= 64) begin
        failures++;
        final_report();
      end
      hiLen[p] = k;
    end
    check("phase offset", 16'(hiLen[0] - hiLen[1]), 16'h000A);
    for (int p = 0; p < 4; p++) begin
      wr(16'h0501, 8'h11 | 8'(p << 2));
      cycles(3);
      repeat (6) begin
        cycles(1);
        check("first polarity", firstPairP ^ firstPairN, !p[0]);
      end
    end
    for (int e = 0; e < 2; e++) begin
      wr(16'h0505, e ? 8'h45 : 8'h15);
      cycles(3);
      check("second polarity", secondPairP ^ secondPairN, e ? 1'h0 : 1'h1);
    end
    for (int f = 0; f < 8; f++) begin
      wr(16'h0501, 8'(f << 4) | 8'h01);
      wr(16'h0505, 8'(f << 4) | 8'h01);
      cycles(4);
      check("first mode", firstPairMode, (f % 4 == 3) ? 3'h0 : 3'(f));
      check("second mode", secondPairMode, (f % 4 == 3) ? 3'h0 : 3'(f));
    end
    foreach (DRV[i]) begin
      wr(16'h0501, DRV[i]);
      cycles(2);
      check("first driver", {firstPairDriverOn, firstPairCmos33, firstPairBoost}, DRV_X[i]);
    end
    for (int e = 0; e < 2; e++) begin
      wr(16'h0505, e ? 8'h13 : 8'h10);
      cycles(2);
      check("second driver", {secondPairDriverOn, secondPairBoost}, e ? 2'h3 : 2'h0);
    end
    wr(16'h0503, 8'h08);
    cycles(2);
    check("running in power down", dividerRunning, 1'h0);
    wr(16'h0503, 8'h00);
    cycles(20);
    check("running after power up", dividerRunning, 1'h0);
    @(posedge clk);
    syncMask <= 1'h1;
    cycles(4);
    check("running with mask", dividerRunning, 1'h1);
    final_report();
  end
endmodule
